// ### logic/cco_top.v
`include "cco_consts.vh"

module cco_top (
  // clock and reset
  input wire MCLK,
  input wire RST_N,
  // serial configuration port
  input wire SCLK,
  input wire CS_N,
  input wire SDI,
  output wire SDO,
  output wire SDO_OE,
  // clock outputs, order A0 A1 A2 B0 B1 C0 C1 D E0 E1
  output reg [9:0] CLOCK_OUTPUT_PIN,
  // analog driver settings per output
  output reg [9:0] OUTPUT_POWER_DOWN,
  output reg [9:0] OUTPUT_STYLE,
  output reg [19:0] OUTPUT_AMPLITUDE
);

  reg rst_s1;
  reg rst_n_int;
  wire [6:0] addr;
  wire [7:0] wdata;
  wire wr;
  reg [7:0] rdata;
  reg [5:0] divide_select [0:4];
  reg [7:0] phase_delay [0:4];
  reg [4:0] channel_power_down;
  reg [7:0] output_state [0:9];
  reg [9:0] output_gate;
  reg [7:0] div_cnt [0:4];
  reg [7:0] wait_cnt [0:4];
  reg [4:0] ch_clk;
  reg [4:0] restart;
  integer i;
  integer j, k, m;

  // ************************************************************
  // divide code table
  // ************************************************************
  function [7:0] ratio;
    input [5:0] code;
    begin
      case (code)
        6'h01: ratio = 8'd1;
        6'h02: ratio = 8'd2;
        6'h03: ratio = 8'd3;
        6'h04: ratio = 8'd4;
        6'h05: ratio = 8'd5;
        6'h06: ratio = 8'd6;
        6'h07: ratio = 8'd8;
        6'h08: ratio = 8'd9;
        6'h09: ratio = 8'd10;
        6'h0a: ratio = 8'd12;
        6'h0b: ratio = 8'd15;
        6'h0c: ratio = 8'd16;
        6'h0d: ratio = 8'd18;
        6'h0e: ratio = 8'd20;
        6'h0f: ratio = 8'd24;
        6'h10: ratio = 8'd25;
        6'h11: ratio = 8'd30;
        6'h12: ratio = 8'd32;
        6'h13: ratio = 8'd36;
        6'h14: ratio = 8'd40;
        6'h15: ratio = 8'd48;
        6'h16: ratio = 8'd50;
        6'h18: ratio = 8'd60;
        6'h19: ratio = 8'd64;
        6'h1a: ratio = 8'd72;
        6'h1b: ratio = 8'd80;
        6'h1d: ratio = 8'd96;
        6'h1e: ratio = 8'd100;
        6'h1f: ratio = 8'd120;
        6'h20: ratio = 8'd128;
        6'h21: ratio = 8'd150;
        6'h22: ratio = 8'd160;
        6'h23: ratio = 8'd200;
        default: ratio = 8'd0;
      endcase
    end
  endfunction

  function [2:0] out_channel;
    input [3:0] idx;
    begin
      case (idx)
        4'h0, 4'h1, 4'h2: out_channel = 3'h0;
        4'h3, 4'h4: out_channel = 3'h1;
        4'h5, 4'h6: out_channel = 3'h2;
        4'h7: out_channel = 3'h3;
        default: out_channel = 3'h4;
      endcase
    end
  endfunction

  function [6:0] out_addr;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: out_addr = ch_addr(3'h0, `CCO_OFS_OUT0);
        4'h1: out_addr = ch_addr(3'h0, `CCO_OFS_OUT1);
        4'h2: out_addr = ch_addr(3'h0, `CCO_OFS_OUT2);
        4'h3: out_addr = ch_addr(3'h1, `CCO_OFS_OUT0);
        4'h4: out_addr = ch_addr(3'h1, `CCO_OFS_OUT1);
        4'h5: out_addr = ch_addr(3'h2, `CCO_OFS_OUT0);
        4'h6: out_addr = ch_addr(3'h2, `CCO_OFS_OUT1);
        4'h7: out_addr = ch_addr(3'h3, `CCO_OFS_OUT0);
        4'h8: out_addr = ch_addr(3'h4, `CCO_OFS_OUT0);
        default: out_addr = ch_addr(3'h4, `CCO_OFS_OUT1);
      endcase
    end
  endfunction

  function [6:0] ch_addr;
    input [2:0] ch;
    input [3:0] ofs;
    begin
      ch_addr = `CCO_CH_BASE + {ch, `CCO_CH_STRIDE_SHIFT'h0} + {3'h0, ofs};
    end
  endfunction

  // ************************************************************
  // reset release
  // ************************************************************
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1 <= 1'b0;
      rst_n_int <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n_int <= rst_s1;
    end
  end

  cco_spi u_spi (
    .clk(MCLK),
    .rst_n(rst_n_int),
    .sclk_pin(SCLK),
    .cs_n_pin(CS_N),
    .sdi_pin(SDI),
    .sdo(SDO),
    .sdo_oe(SDO_OE),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rdata(rdata)
  );

  // ************************************************************
  // register file
  // ************************************************************
  always @(posedge MCLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      for (i = 0; i < `CCO_CH_COUNT; i = i + 1)
      begin
        divide_select[i] <= `CCO_DIV_RESET;
        phase_delay[i] <= `CCO_PHASE_RESET;
      end
      for (i = 0; i < `CCO_OUT_COUNT; i = i + 1)
        output_state[i] <= `CCO_STATE_RESET;
      channel_power_down <= 5'h00;
      output_gate <= `CCO_GATE_RESET;
      restart <= 5'h00;
    end
    else
    begin
      restart <= 5'h00;
      if (wr)
      begin
        for (i = 0; i < `CCO_CH_COUNT; i = i + 1)
        begin
          if (addr == ch_addr(i[2:0], `CCO_OFS_DIVIDE))
            divide_select[i] <= wdata[5:0];
          if (addr == ch_addr(i[2:0], `CCO_OFS_PHASE))
            phase_delay[i] <= wdata;
          if (addr == ch_addr(i[2:0], `CCO_OFS_DIVIDE) || addr == ch_addr(i[2:0], `CCO_OFS_PHASE))
            restart[i] <= 1'b1;
          if (addr == ch_addr(i[2:0], `CCO_OFS_POWER))
            channel_power_down[i] <= wdata[`CCO_PD_BIT];
        end
        for (i = 0; i < `CCO_OUT_COUNT; i = i + 1)
          if (addr == out_addr(i[3:0]))
            output_state[i] <= wdata & `CCO_STATE_MASK;
        if (addr == `CCO_ADDR_GATE_LO)
          for (i = 0; i < `CCO_GATE_LO_COUNT; i = i + 1)
            output_gate[i] <= wdata[`CCO_GATE_LO_TOP - i];
        if (addr == `CCO_ADDR_GATE_HI)
          output_gate[9:8] <= wdata[1:0];
      end
    end
  end

  always @*
  begin
    rdata = 8'h00;
    for (j = 0; j < `CCO_CH_COUNT; j = j + 1)
    begin
      if (addr == ch_addr(j[2:0], `CCO_OFS_DIVIDE))
        rdata = {2'h0, divide_select[j]};
      if (addr == ch_addr(j[2:0], `CCO_OFS_PHASE))
        rdata = phase_delay[j];
      if (addr == ch_addr(j[2:0], `CCO_OFS_POWER))
        rdata = {channel_power_down[j], 7'h00};
    end
    for (j = 0; j < `CCO_OUT_COUNT; j = j + 1)
      if (addr == out_addr(j[3:0]))
        rdata = output_state[j];
    if (addr == `CCO_ADDR_GATE_LO)
      rdata = {output_gate[0], output_gate[1], output_gate[2], output_gate[3],
               output_gate[4], output_gate[5], output_gate[6], output_gate[7]};
    if (addr == `CCO_ADDR_GATE_HI)
      rdata = {6'h00, output_gate[9], output_gate[8]} & `CCO_GATE_HI_MASK;
  end

  // ************************************************************
  // channel dividers
  // ************************************************************
  always @(posedge MCLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      for (k = 0; k < `CCO_CH_COUNT; k = k + 1)
      begin
        div_cnt[k] <= 8'h00;
        wait_cnt[k] <= 8'h00;
      end
      ch_clk <= 5'h00;
    end
    else
    begin
      for (k = 0; k < `CCO_CH_COUNT; k = k + 1)
      begin
        if (channel_power_down[k] || restart[k] || ratio(divide_select[k]) == 8'h00)
        begin
          // held stopped; start is delayed by the phase code
          div_cnt[k] <= 8'h00;
          wait_cnt[k] <= phase_delay[k];
          ch_clk[k] <= 1'b0;
        end
        else if (wait_cnt[k] != 8'h00)
          wait_cnt[k] <= wait_cnt[k] - 8'h01;
        else
        begin
          ch_clk[k] <= div_cnt[k] < ((ratio(divide_select[k]) + 8'h01) >> 1);
          if (div_cnt[k] == ratio(divide_select[k]) - 8'h01)
            div_cnt[k] <= 8'h00;
          else
            div_cnt[k] <= div_cnt[k] + 8'h01;
        end
      end
    end
  end

  // ************************************************************
  // output gating and driver settings
  // ************************************************************
  always @(posedge MCLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      CLOCK_OUTPUT_PIN <= 10'h000;
      OUTPUT_POWER_DOWN <= 10'h000;
      OUTPUT_STYLE <= 10'h000;
      OUTPUT_AMPLITUDE <= 20'h00000;
    end
    else
    begin
      for (m = 0; m < `CCO_OUT_COUNT; m = m + 1)
      begin
        CLOCK_OUTPUT_PIN[m] <= ch_clk[out_channel(m[3:0])] & output_gate[m]
          & ~output_state[m][`CCO_PD_BIT]
          & ~channel_power_down[out_channel(m[3:0])];
        OUTPUT_POWER_DOWN[m] <= output_state[m][`CCO_PD_BIT];
        OUTPUT_STYLE[m] <= output_state[m][`CCO_STYLE_BIT];
        OUTPUT_AMPLITUDE[2 * m +: 2] <= output_state[m][`CCO_AMP_HI:`CCO_AMP_LO];
      end
    end
  end

endmodule

// ### logic/cco_consts.vh
`ifndef CCO_CONSTS_VH
`define CCO_CONSTS_VH
// ************************************************************
// register map
// ************************************************************
`define CCO_CH_BASE 7'h20
`define CCO_CH_STRIDE_SHIFT 4
`define CCO_CH_COUNT 5
`define CCO_OUT_COUNT 10
`define CCO_OFS_DIVIDE 4'h0
`define CCO_OFS_PHASE 4'h1
`define CCO_OFS_POWER 4'h2
`define CCO_ADDR_GATE_LO 7'h74
`define CCO_ADDR_GATE_HI 7'h75
`define CCO_OFS_OUT0 4'h4
`define CCO_OFS_OUT1 4'h5
`define CCO_OFS_OUT2 4'h6
`define CCO_GATE_LO_COUNT 8
`define CCO_GATE_LO_TOP 7
// ************************************************************
// field layouts and reset values
// ************************************************************
`define CCO_DIV_MASK 8'h3f
`define CCO_DIV_RESET 6'h11
`define CCO_PHASE_RESET 8'h00
`define CCO_PD_BIT 7
`define CCO_STATE_MASK 8'h9c
`define CCO_STATE_RESET 8'h00
`define CCO_STYLE_BIT 4
`define CCO_AMP_HI 3
`define CCO_AMP_LO 2
`define CCO_GATE_HI_MASK 8'h03
`define CCO_GATE_RESET 10'h000
// ************************************************************
// serial frame
// ************************************************************
`define CCO_ADDR_BITS 4'h8
`define CCO_FRAME_BITS 5'h10
`endif

// ### logic/cco_spi.v
`include "cco_consts.vh"

module cco_spi (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial pins
  input wire sclk_pin,
  input wire cs_n_pin,
  input wire sdi_pin,
  output reg sdo,
  output reg sdo_oe,
  // register side
  output reg [6:0] addr,
  output reg [7:0] wdata,
  output reg wr,
  input wire [7:0] rdata
);

  reg [2:0] sync1;
  reg [2:0] sync2;
  reg sclk_d;
  reg [4:0] bitcnt;
  reg [7:0] shift;
  reg [7:0] tx;
  reg is_read;
  reg load;
  wire sclk_s = sync2[0];
  wire cs_s = sync2[1];
  wire sdi_s = sync2[2];
  wire rise = sclk_s & ~sclk_d;
  wire fall = ~sclk_s & sclk_d;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 3'h2;
      sync2 <= 3'h2;
      sclk_d <= 1'b0;
      bitcnt <= 5'h00;
      shift <= 8'h00;
      tx <= 8'h00;
      is_read <= 1'b0;
      load <= 1'b0;
      addr <= 7'h00;
      wdata <= 8'h00;
      wr <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else
    begin
      sync1 <= {sdi_pin, cs_n_pin, sclk_pin};
      sync2 <= sync1;
      sclk_d <= sclk_s;
      wr <= 1'b0;
      load <= 1'b0;
      if (cs_s)
      begin
        bitcnt <= 5'h00;
        sdo_oe <= 1'b0;
        sdo <= 1'b0;
      end
      else
      begin
        if (rise)
        begin
          shift <= {shift[6:0], sdi_s};
          bitcnt <= bitcnt + 5'h01;
          if (bitcnt == {1'b0, `CCO_ADDR_BITS} - 5'h01)
          begin
            is_read <= shift[6];
            addr <= {shift[5:0], sdi_s};
            load <= 1'b1;
          end
          if (bitcnt == `CCO_FRAME_BITS - 5'h01 && !is_read)
          begin
            wdata <= {shift[6:0], sdi_s};
            wr <= 1'b1;
          end
        end
        // read data leaves msb first, advanced on falling sclk
        if (load && is_read)
        begin
          tx <= rdata;
          sdo <= rdata[7];
          sdo_oe <= 1'b1;
        end
        else if (fall && is_read && bitcnt > {1'b0, `CCO_ADDR_BITS})
        begin
          tx <= {tx[6:0], 1'b0};
          sdo <= tx[6];
          if (bitcnt == `CCO_FRAME_BITS)
            sdo_oe <= 1'b0;
        end
      end
    end
  end

endmodule

// ### sim/cco_chk_assertions.sv
// ****************
// port checker
// ****************
module cco_chk (
  // clock and reset
  input logic MCLK,
  input logic RST_N,
  // serial port
  input logic SCLK,
  input logic CS_N,
  input logic SDI,
  input logic SDO,
  input logic SDO_OE,
  // outputs
  input logic [9:0] CLOCK_OUTPUT_PIN,
  input logic [9:0] OUTPUT_POWER_DOWN,
  input logic [9:0] OUTPUT_STYLE,
  input logic [19:0] OUTPUT_AMPLITUDE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] age;
  always @(posedge MCLK or negedge RST_N)
    if (!RST_N)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_cs_idle4;
    CS_N [*4];
  endsequence
  sequence s_cs_idle8;
    CS_N [*8];
  endsequence
  property p_reset_zero;
    age < 2'h2 |-> {CLOCK_OUTPUT_PIN, OUTPUT_POWER_DOWN, OUTPUT_STYLE, OUTPUT_AMPLITUDE} == 50'h0;
  endproperty
  property p_pd_gate;
    (OUTPUT_POWER_DOWN & $past(OUTPUT_POWER_DOWN) & CLOCK_OUTPUT_PIN) == 10'h0;
  endproperty
  property p_pd_stable;
    s_cs_idle8 |-> $stable(OUTPUT_POWER_DOWN);
  endproperty
  property p_style_stable;
    s_cs_idle8 |-> $stable(OUTPUT_STYLE);
  endproperty
  property p_amp_stable;
    s_cs_idle8 |-> $stable(OUTPUT_AMPLITUDE);
  endproperty
  property p_sdo_quiet;
    !SDO_OE |-> !SDO;
  endproperty
  property p_oe_drop;
    s_cs_idle4 |=> !SDO_OE;
  endproperty
  property p_oe_start;
    $rose(SDO_OE) |-> $past(CS_N, 3) == 1'b0;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("outputs not clear after reset");
  a_pd_gate: assert property (p_pd_gate)
    else $error("powered-down output toggles");
  a_pd_stable: assert property (p_pd_stable)
    else $error("power-down changed without a frame");
  a_style_stable: assert property (p_style_stable)
    else $error("style changed without a frame");
  a_amp_stable: assert property (p_amp_stable)
    else $error("amplitude changed without a frame");
  a_sdo_quiet: assert property (p_sdo_quiet)
    else $error("read data high while not driving");
  a_oe_drop: assert property (p_oe_drop)
    else $error("read driver left on after deselect");
  a_oe_start: assert property (p_oe_start)
    else $error("read driver on without select");
endmodule

// ### sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 0, RST_N = 0, SCLK = 0, CS_N = 1, SDI = 0;
  wire SDO, SDO_OE;
  wire [9:0] CLOCK_OUTPUT_PIN, OUTPUT_POWER_DOWN, OUTPUT_STYLE;
  wire [19:0] OUTPUT_AMPLITUDE;
  int fails = 0, n_compared = 0, cyc = 0, c;
  logic [7:0] mm [128];
  logic [7:0] q;
  logic [6:0] oa [10] = '{7'h24, 7'h25, 7'h26, 7'h34, 7'h35, 7'h44, 7'h45, 7'h54, 7'h64, 7'h65};
  int dc [7] = '{'h01, 'h02, 'h03, 'h09, 'h11, 'h12, 'h00};
  int dn [7] = '{1, 2, 3, 10, 30, 32, 10};
  cco_top cco_top_i (.MCLK(MCLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI),
    .SDO(SDO), .SDO_OE(SDO_OE), .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN),
    .OUTPUT_POWER_DOWN(OUTPUT_POWER_DOWN), .OUTPUT_STYLE(OUTPUT_STYLE),
    .OUTPUT_AMPLITUDE(OUTPUT_AMPLITUDE));
  initial
    forever #12.5 MCLK = ~MCLK;
  // ****************
  // reference model
  // ****************
  function automatic logic [7:0] msk(input logic [6:0] a);
    if (a == 7'h74) return 8'hff;
    if (a == 7'h75) return 8'h03;
    for (int i = 0; i < 10; i++)
      if (a == oa[i]) return 8'h9c;
    if (a[6:4] >= 3'h2 && a[6:4] <= 3'h6)
      case (a[3:0])
        4'h0: return 8'h3f;
        4'h1: return 8'hff;
        4'h2: return 8'h80;
        default: return 8'h00;
      endcase
    return 8'h00;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************
  // drivers
  // ****************
  task automatic do_reset();
    RST_N = 0;
    repeat (10) @(negedge MCLK);
    RST_N = 1;
    repeat (4) @(negedge MCLK);
    for (int a = 0; a < 128; a++)
      mm[a] = (msk(a[6:0]) == 8'h3f) ? 8'h11 : 8'h00;
  endtask
  // one 16-bit frame, each serial phase 6 clocks
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] r);
    logic [15:0] f;
    f = {rd, a, d};
    CS_N = 0;
    for (int i = 15; i >= 0; i--)
    begin
      SDI = f[i];
      repeat (6) @(negedge MCLK);
      if (i < 8) r[i] = SDO;
      SCLK = 1;
      repeat (6) @(negedge MCLK);
      SCLK = 0;
    end
    repeat (6) @(negedge MCLK);
    CS_N = 1;
    SDI = ~SDI;
    repeat (6) @(negedge MCLK);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer(1'b0, a, d, q);
    mm[a] = d & msk(a);
  endtask
  task automatic rd_chk(input logic [6:0] a);
    xfer(1'b1, a, 8'h00, q);
    chk(q, mm[a]);
  endtask
  task automatic port_chk();
    for (int i = 0; i < 10; i++)
      chk({OUTPUT_POWER_DOWN[i], OUTPUT_STYLE[i], OUTPUT_AMPLITUDE[2*i+:2]},
        {mm[oa[i]][7], mm[oa[i]][4], mm[oa[i]][3:2]});
  endtask
  task automatic cnt(input int p, input int w, output int n);
    n = 0;
    repeat (w)
    begin
      @(negedge MCLK);
      n += (CLOCK_OUTPUT_PIN[p] === 1'b1);
    end
  endtask
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      fails++;
      print_verdict();
    end
  end
  // ****************
  // scenarios
  // ****************
  initial
  begin
    void'($urandom(40864));
    do_reset();
    for (int a = 'h20; a < 'h80; a++) rd_chk(a[6:0]);
    port_chk();
    for (int a = 'h20; a < 'h80; a++) wr(a[6:0], 8'($urandom));
    for (int a = 'h20; a < 'h80; a++) rd_chk(a[6:0]);
    port_chk();
    do_reset();
    for (int a = 'h20; a < 'h27; a++) rd_chk(a[6:0]);
    cnt(0, 60, c);
    chk(c, 0);
    wr(7'h74, 8'hff);
    wr(7'h75, 8'h03);
    for (int k = 0; k < 7; k++)
    begin
      wr(7'h20, 8'(dc[k]));
      repeat (10) @(negedge MCLK);
      cnt(0, 4 * dn[k], c);
      chk(c, dc[k] == 0 ? 0 : 4 * ((dn[k] + 1) / 2));
    end
    wr(7'h20, 8'h11);
    wr(7'h25, 8'h80);
    wr(7'h74, 8'hdf);
    port_chk();
    cnt(1, 60, c);
    chk(c, 0);
    cnt(2, 60, c);
    chk(c, 0);
    cnt(0, 60, c);
    chk(c, 30);
    wr(7'h22, 8'h80);
    cnt(0, 60, c);
    chk(c, 0);
    cnt(3, 60, c);
    chk(c, 30);
    wr(7'h31, 8'h64);
    cnt(3, 80, c);
    chk(c, 0);
    cnt(3, 60, c);
    chk(c > 0, 1);
    for (int p = 4; p < 10; p++)
    begin
      cnt(p, 60, c);
      chk(c, 30);
    end
    print_verdict();
  end
endmodule

bind cco_top cco_chk cco_chk_i (.MCLK(MCLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N),
  .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE), .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN),
  .OUTPUT_POWER_DOWN(OUTPUT_POWER_DOWN), .OUTPUT_STYLE(OUTPUT_STYLE),
  .OUTPUT_AMPLITUDE(OUTPUT_AMPLITUDE));
